// [tctc_pin_model.sv]
// External count pin source for the timer.
// Assumes the caller runs on ref_clk; pin idles low between bursts.
`timescale 1ns/10ps
`default_nettype none
module tctc_pin_model (
	input wire logic ref_clk,
	output logic pinLevel
);
	initial pinLevel = 1'b0;
	task automatic send_edges(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			pinLevel <= 1'b1;
			repeat (4) @(posedge ref_clk);
			pinLevel <= 1'b0;
			repeat (3) @(posedge ref_clk);
		end
	endtask : send_edges
endmodule : tctc_pin_model
`default_nettype wire

// [tctc_pkg.sv]
// Constants, field layouts and carrier types of the two-compare timer.
// Assumes an APB slave with 32-bit data; registers sit in the low byte.
// Notes on behaviour
// - Counter and both compares are 8 bits
// - Zero is bottom, 0xFF is max
// - Top is 0xFF or compare A
// - Tick select field; zero stops counter
// - Tick from prescaler or external pin
// - Software counter write beats clear/count
// - Three-bit waveform mode over two controls
// - Equality sets match flag next tick
// - Flag cleared by service or writing one
// - Flag register; mask gates each request
// - Overflow point depends on mode
// - Compares double buffered only in PWM
// - Buffer loads at top or bottom
// - Software writes buffer when buffering
// - Force strobe acts like match outside PWM, no flag
// - Counter write blocks next tick's match
// - Output mode bits act immediately
// - Wave state kept across mode changes
// - Waveform from match and bottom
// - Normal mode wraps; overflow at max
// - Clear-on-match mode clears at compare A
// - Fast PWM modes 3 and 7
// - Output mode zero leaves wave untouched
package tctc_pkg;
	localparam logic [11:0] ADDR_CONTROL_A = 12'h000;
	localparam logic [11:0] ADDR_CONTROL_B = 12'h004;
	localparam logic [11:0] ADDR_COUNT = 12'h008;
	localparam logic [11:0] ADDR_COMPARE_A = 12'h00C;
	localparam logic [11:0] ADDR_COMPARE_B = 12'h010;
	localparam logic [11:0] ADDR_MASK = 12'h014;
	localparam logic [11:0] ADDR_FLAG = 12'h018;
	localparam logic [11:0] ADDR_SERVICE = 12'h01C;
	localparam logic [7:0] COUNT_BOTTOM = 8'h00;
	localparam logic [7:0] COUNT_MAX = 8'hFF;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam int FLAG_OVF_POS = 0;
	localparam int FLAG_A_POS = 1;
	localparam int FLAG_B_POS = 2;
	localparam int CTLA_COMB_POS = 4;
	localparam int CTLA_COMA_POS = 6;
	localparam int CTLB_FOCB_POS = 6;
	localparam int CTLB_FOCA_POS = 7;
	localparam int CTLB_WGM2_POS = 3;
	localparam int PRESCALE_W = 10;
	typedef enum logic [2:0] {
		TCTC_NORMAL = 3'b000,
		TCTC_PC_MAX = 3'b001,
		TCTC_CTC = 3'b010,
		TCTC_FAST_MAX = 3'b011,
		TCTC_RSV4 = 3'b100,
		TCTC_PC_OCRA = 3'b101,
		TCTC_RSV6 = 3'b110,
		TCTC_FAST_OCRA = 3'b111
	} tctc_mode_t;
	typedef enum logic [2:0] {
		TCTC_STOP = 3'b000,
		TCTC_DIV1 = 3'b001,
		TCTC_DIV8 = 3'b010,
		TCTC_DIV64 = 3'b011,
		TCTC_DIV256 = 3'b100,
		TCTC_DIV1024 = 3'b101,
		TCTC_EXT_FALL = 3'b110,
		TCTC_EXT_RISE = 3'b111
	} tctc_tick_t;
	typedef struct packed {
		logic waveOutA;
		logic waveOutB;
		logic waveEnableA;
		logic waveEnableB;
	} tctc_wave_t;
	typedef struct packed {
		logic reqOverflow;
		logic reqMatchA;
		logic reqMatchB;
	} tctc_irq_t;
endpackage : tctc_pkg

// [tctc_timer.sv]
// Two-compare 8-bit timer/counter with APB register access.
// Assumes ref_clk domain APB master; external count pin is asynchronous.
`timescale 1ns/10ps
`default_nettype none
module tctc_timer (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic externalCountInput,
	output tctc_pkg::tctc_wave_t wave,
	output tctc_pkg::tctc_irq_t irq
);
	import tctc_pkg::*;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] countValue;
	logic [7:0] compareValueA;
	logic [7:0] compareValueB;
	logic [7:0] bufferA;
	logic [7:0] bufferB;
	logic [1:0] compareOutputModeA;
	logic [1:0] compareOutputModeB;
	logic [2:0] waveformModeField;
	logic [2:0] tickSourceSelect;
	logic [2:0] timerMaskReg;
	logic [2:0] timerFlagReg;
	logic waveA;
	logic waveB;
	logic blockMatch;
	logic [PRESCALE_W-1:0] prescale;
	logic extSync1;
	logic extSync2;
	logic extPrev;

	logic wrEn;
	logic rdEn;
	logic mapped;
	logic pwmMode;
	logic timerTick;
	logic isBottom;
	logic isMax;
	logic isTop;
	logic [7:0] topValue;
	logic matchA;
	logic matchB;
	logic forceA;
	logic forceB;
	logic countWrite;
	logic [7:0] next_count;
	logic [2:0] flagSet;
	tctc_mode_t mode;

	// Non-PWM output action: 1 toggle, 2 clear, 3 set
	function automatic logic nonPwmAction(input logic [1:0] com, input logic cur);
		case (com)
			2'b01: nonPwmAction = ~cur;
			2'b10: nonPwmAction = 1'b0;
			2'b11: nonPwmAction = 1'b1;
			default: nonPwmAction = cur;
		endcase
	endfunction : nonPwmAction

	// Divider tap for the selected prescale
	function automatic logic divTap(input logic [2:0] sel, input logic [PRESCALE_W-1:0] pre);
		case (sel)
			TCTC_DIV1: divTap = 1'b1;
			TCTC_DIV8: divTap = &pre[2:0];
			TCTC_DIV64: divTap = &pre[5:0];
			TCTC_DIV256: divTap = &pre[7:0];
			TCTC_DIV1024: divTap = &pre[9:0];
			default: divTap = 1'b0;
		endcase
	endfunction : divTap

	assign mode = tctc_mode_t'(waveformModeField);
	assign wrEn = psel & penable & pwrite & clkEn;
	assign rdEn = psel & ~pwrite;
	assign pready = 1'b1;
	assign mapped = (paddr <= ADDR_SERVICE) && (paddr[1:0] == 2'b00);
	assign pslverr = psel & penable & ~mapped;
	assign countWrite = wrEn && paddr == ADDR_COUNT;

	// ----------------------------------------
	// Tick source
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			extSync1 <= 1'b0;
			extSync2 <= 1'b0;
			extPrev <= 1'b0;
		end else if (clkEn) begin
			extSync1 <= externalCountInput;
			extSync2 <= extSync1;
			extPrev <= extSync2;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prescale <= '0;
		end else if (clkEn) begin
			prescale <= prescale + 1'b1;
		end
	end

	always_comb begin
		case (tickSourceSelect)
			TCTC_EXT_FALL: timerTick = extPrev & ~extSync2;
			TCTC_EXT_RISE: timerTick = ~extPrev & extSync2;
			TCTC_STOP: timerTick = 1'b0;
			default: timerTick = divTap(tickSourceSelect, prescale);
		endcase
	end

	// ----------------------------------------
	// Counter unit
	// ----------------------------------------
	// PWM mode decode
	assign pwmMode = waveformModeField[0];
	assign isBottom = countValue == COUNT_BOTTOM;
	assign isMax = countValue == COUNT_MAX;
	assign topValue = (mode == TCTC_CTC || waveformModeField[2]) ? compareValueA : COUNT_MAX;
	assign isTop = countValue == topValue;
	assign matchA = countValue == compareValueA;
	assign matchB = countValue == compareValueB;

	always_comb begin
		next_count = countValue + 8'h01;
		if (mode == TCTC_CTC || mode == TCTC_FAST_MAX || mode == TCTC_FAST_OCRA) begin
			if (isTop) begin
				next_count = COUNT_BOTTOM;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			countValue <= RESET_BYTE;
		end else if (clkEn) begin
			if (countWrite) begin
				countValue <= pwdata[7:0];
			end else if (timerTick) begin
				countValue <= next_count;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			blockMatch <= 1'b0;
		end else if (clkEn) begin
			if (countWrite) begin
				blockMatch <= 1'b1;
			end else if (timerTick) begin
				blockMatch <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Compare registers
	// ----------------------------------------
	// buffer or direct write
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bufferA <= RESET_BYTE;
			bufferB <= RESET_BYTE;
		end else if (clkEn && wrEn) begin
			if (paddr == ADDR_COMPARE_A) begin
				bufferA <= pwdata[7:0];
			end
			if (paddr == ADDR_COMPARE_B) begin
				bufferB <= pwdata[7:0];
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			compareValueA <= RESET_BYTE;
			compareValueB <= RESET_BYTE;
		end else if (clkEn) begin
			if (!pwmMode) begin
				if (wrEn && paddr == ADDR_COMPARE_A) begin
					compareValueA <= pwdata[7:0];
				end
				if (wrEn && paddr == ADDR_COMPARE_B) begin
					compareValueB <= pwdata[7:0];
				end
			end else if (timerTick && (isTop || isBottom)) begin
				compareValueA <= bufferA;
				compareValueB <= bufferB;
			end
		end
	end

	// ----------------------------------------
	// Control, mask and flags
	// ----------------------------------------
	// control fields
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			compareOutputModeA <= 2'h0;
			compareOutputModeB <= 2'h0;
			waveformModeField <= 3'h0;
			tickSourceSelect <= 3'h0;
			timerMaskReg <= 3'h0;
		end else if (clkEn && wrEn) begin
			if (paddr == ADDR_CONTROL_A) begin
				compareOutputModeA <= pwdata[CTLA_COMA_POS+:2];
				compareOutputModeB <= pwdata[CTLA_COMB_POS+:2];
				waveformModeField[1:0] <= pwdata[1:0];
			end
			if (paddr == ADDR_CONTROL_B) begin
				waveformModeField[2] <= pwdata[CTLB_WGM2_POS];
				tickSourceSelect <= pwdata[2:0];
			end
			if (paddr == ADDR_MASK) begin
				timerMaskReg <= pwdata[2:0];
			end
		end
	end

	assign forceA = wrEn && paddr == ADDR_CONTROL_B && pwdata[CTLB_FOCA_POS] && !pwmMode;
	assign forceB = wrEn && paddr == ADDR_CONTROL_B && pwdata[CTLB_FOCB_POS] && !pwmMode;

	always_comb begin
		flagSet = 3'b000;
		if (timerTick) begin
			flagSet[FLAG_A_POS] = matchA & ~blockMatch;
			flagSet[FLAG_B_POS] = matchB & ~blockMatch;
			if (pwmMode && !waveformModeField[1]) begin
				flagSet[FLAG_OVF_POS] = isBottom;
			end else if (waveformModeField[1] && pwmMode) begin
				flagSet[FLAG_OVF_POS] = isTop;
			end else begin
				flagSet[FLAG_OVF_POS] = isMax;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			timerFlagReg <= 3'h0;
		end else if (clkEn) begin
			if (wrEn && paddr == ADDR_FLAG) begin
				timerFlagReg <= (timerFlagReg & ~pwdata[2:0]) | flagSet;
			end else if (wrEn && paddr == ADDR_SERVICE) begin
				timerFlagReg <= (timerFlagReg & ~pwdata[2:0]) | flagSet;
			end else begin
				timerFlagReg <= timerFlagReg | flagSet;
			end
		end
	end

	assign irq.reqOverflow = timerFlagReg[FLAG_OVF_POS] & timerMaskReg[FLAG_OVF_POS];
	assign irq.reqMatchA = timerFlagReg[FLAG_A_POS] & timerMaskReg[FLAG_A_POS];
	assign irq.reqMatchB = timerFlagReg[FLAG_B_POS] & timerMaskReg[FLAG_B_POS];

	// ----------------------------------------
	// Waveform generator
	// ----------------------------------------
	// unit A
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			waveA <= 1'b0;
		end else if (clkEn) begin
			if (forceA) begin
				waveA <= nonPwmAction(compareOutputModeA, waveA);
			end else if (timerTick && compareOutputModeA[1]) begin
				if (pwmMode && matchA && !blockMatch) begin
					waveA <= compareOutputModeA[0];
				end else if (pwmMode && isBottom) begin
					waveA <= ~compareOutputModeA[0];
				end else if (!pwmMode && matchA && !blockMatch) begin
					waveA <= nonPwmAction(compareOutputModeA, waveA);
				end
			end else if (timerTick && !pwmMode && matchA && !blockMatch) begin
				waveA <= nonPwmAction(compareOutputModeA, waveA);
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			waveB <= 1'b0;
		end else if (clkEn) begin
			if (forceB) begin
				waveB <= nonPwmAction(compareOutputModeB, waveB);
			end else if (timerTick && compareOutputModeB[1]) begin
				if (pwmMode && matchB && !blockMatch) begin
					waveB <= compareOutputModeB[0];
				end else if (pwmMode && isBottom) begin
					waveB <= ~compareOutputModeB[0];
				end else if (!pwmMode && matchB && !blockMatch) begin
					waveB <= nonPwmAction(compareOutputModeB, waveB);
				end
			end else if (timerTick && !pwmMode && matchB && !blockMatch) begin
				waveB <= nonPwmAction(compareOutputModeB, waveB);
			end
		end
	end

	assign wave.waveOutA = waveA;
	assign wave.waveOutB = waveB;
	assign wave.waveEnableA = compareOutputModeA != 2'b00;
	assign wave.waveEnableB = compareOutputModeB != 2'b00;

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0;
		end else if (clkEn && rdEn && !penable) begin
			case (paddr)
				ADDR_CONTROL_A: prdata <= {24'h0, compareOutputModeA, compareOutputModeB,
					2'b00, waveformModeField[1:0]};
				ADDR_CONTROL_B: prdata <= {28'h0, waveformModeField[2], tickSourceSelect};
				ADDR_COUNT: prdata <= {24'h0, countValue};
				ADDR_COMPARE_A: prdata <= {24'h0, pwmMode ? bufferA : compareValueA};
				ADDR_COMPARE_B: prdata <= {24'h0, pwmMode ? bufferB : compareValueB};
				ADDR_MASK: prdata <= {29'h0, timerMaskReg};
				ADDR_FLAG: prdata <= {29'h0, timerFlagReg};
				default: prdata <= 32'h0;
			endcase
		end
	end
endmodule : tctc_timer
`default_nettype wire

// [tctc_timer_sva.sv]
// Port-level checker for the two-compare timer.
// Bound to tctc_timer; sees only its ports, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module tctc_timer_sva (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire tctc_pkg::tctc_wave_t wave,
	input wire tctc_pkg::tctc_irq_t irq
);
	import tctc_pkg::*;
	logic wr;
	logic bad;
	assign wr = psel && penable && pwrite && clkEn;
	assign bad = (paddr > ADDR_SERVICE) || (paddr[1:0] != 2'h0);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	ready_high_a: assert property (pready)
		else $error("pready low");
	unmapped_err_a: assert property (psel && penable && bad |-> pslverr)
		else $error("no error on unmapped access");
	mapped_ok_a: assert property (psel && penable && !bad |-> !pslverr)
		else $error("error on mapped access");
	unmapped_zero_a: assert property (clkEn && psel && !penable && !pwrite && bad |=> prdata == 32'h0)
		else $error("unmapped read not zero");
	mask_off_a: assert property (wr && paddr == ADDR_MASK && pwdata[2:0] == 3'h0 |=> irq == 3'h0)
		else $error("request despite cleared mask");
	enable_on_a: assert property (wr && paddr == ADDR_CONTROL_A && pwdata[7:6] != 2'h0
		|=> wave.waveEnableA)
		else $error("output A not enabled");
	enable_off_a: assert property (wr && paddr == ADDR_CONTROL_A && pwdata[5:4] == 2'h0
		|=> !wave.waveEnableB)
		else $error("output B enabled");
	reset_clear_a: assert property ($fell(rst) |-> wave == 4'h0 && irq == 3'h0)
		else $error("state not cleared by reset");
	freeze_hold_a: assert property (!clkEn |=> $stable(wave.waveOutA) && $stable(wave.waveOutB))
		else $error("wave changed while frozen");
endmodule : tctc_timer_sva
bind tctc_timer tctc_timer_sva u_tctc_timer_sva (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .wave(wave), .irq(irq));
`default_nettype wire

// [test_timer_counter_two_compare.sv]
// Self-checking bench for the two-compare timer.
// Assumes tctc_pkg, tctc_timer, its checker and the pin model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_timer_counter_two_compare;
	import tctc_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic clkEn = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pin;
	tctc_wave_t wave;
	tctc_irq_t irq;
	logic [31:0] d;
	int errCount = 0;
	int testsRun = 0;
	tctc_timer u_tctc_timer (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .externalCountInput(pin), .wave(wave), .irq(irq));
	tctc_pin_model u_tctc_pin_model (.ref_clk(ref_clk), .pinLevel(pin));
	always #20 ref_clk = ~ref_clk;
	// ----------------------------------------
	// Bus and check helpers
	// ----------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		d = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge ref_clk);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		apb(1'b1, a, v);
	endtask : wr
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rd
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		testsRun++;
		if (seen !== want) begin
			errCount++;
			$display("MISMATCH %0t saw %h want %h", $time, seen, want);
		end
	endtask : check
	task automatic tally_and_finish();
		if (errCount == 0 && testsRun > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : tally_and_finish
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		for (int a = 0; a <= 32; a += 4) begin
			rd(a[11:0]);
			check(d, 32'h0);
		end
		wr(ADDR_COUNT, 32'h1AB);
		rd(ADDR_COUNT);
		check(d, 32'hAB);
	endtask : t_reset
	task automatic t_ovf();
		wr(ADDR_COUNT, 32'hFE);
		wr(ADDR_MASK, 32'h1);
		wr(ADDR_CONTROL_B, 32'h1);
		repeat (4) @(posedge ref_clk);
		rd(ADDR_FLAG);
		check(d & 32'h1, 32'h1);
		check({31'h0, irq.reqOverflow}, 32'h1);
		wr(ADDR_CONTROL_B, 32'h0);
		wr(ADDR_FLAG, 32'h7);
		rd(ADDR_FLAG);
		check(d, 32'h0);
		wr(ADDR_MASK, 32'h0);
	endtask : t_ovf
	task automatic t_ctc();
		wr(ADDR_COUNT, 32'h0);
		wr(ADDR_COMPARE_A, 32'h3);
		wr(ADDR_CONTROL_A, 32'h2);
		wr(ADDR_FLAG, 32'h7);
		wr(ADDR_CONTROL_B, 32'h1);
		repeat (3) begin
			rd(ADDR_COUNT);
			check({31'h0, d <= 32'h3}, 32'h1);
		end
		wr(ADDR_CONTROL_B, 32'h0);
		rd(ADDR_FLAG);
		check(d & 32'h2, 32'h2);
		wr(ADDR_MASK, 32'h2);
		check({31'h0, irq.reqMatchA}, 32'h1);
		wr(ADDR_MASK, 32'h0);
		wr(ADDR_CONTROL_A, 32'h0);
	endtask : t_ctc
	task automatic t_block();
		wr(ADDR_COMPARE_A, 32'h20);
		wr(ADDR_COUNT, 32'h20);
		wr(ADDR_FLAG, 32'h7);
		wr(ADDR_CONTROL_B, 32'h1);
		wr(ADDR_CONTROL_B, 32'h0);
		rd(ADDR_FLAG);
		check(d & 32'h2, 32'h0);
	endtask : t_block
	task automatic t_force();
		logic w;
		wr(ADDR_CONTROL_B, 32'h80);
		check({31'h0, wave.waveOutA}, 32'h0);
		wr(ADDR_CONTROL_A, 32'h40);
		check({31'h0, wave.waveEnableA}, 32'h1);
		w = wave.waveOutA;
		wr(ADDR_CONTROL_B, 32'h80);
		check({31'h0, wave.waveOutA}, {31'h0, ~w});
		@(posedge ref_clk);
		clkEn <= 1'b0;
		wr(ADDR_CONTROL_B, 32'h80);
		@(posedge ref_clk);
		clkEn <= 1'b1;
		wr(ADDR_CONTROL_A, 32'h43);
		check({31'h0, wave.waveOutA}, {31'h0, ~w});
		rd(ADDR_FLAG);
		check(d, 32'h0);
		wr(ADDR_CONTROL_A, 32'h0);
	endtask : t_force
	task automatic t_ext();
		wr(ADDR_COUNT, 32'h0);
		wr(ADDR_CONTROL_B, 32'h7);
		u_tctc_pin_model.send_edges(3);
		repeat (6) @(posedge ref_clk);
		wr(ADDR_CONTROL_B, 32'h0);
		rd(ADDR_COUNT);
		check(d, 32'h3);
	endtask : t_ext
	initial begin
		#200000;
		errCount++;
		tally_and_finish();
	end
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_ovf();
		t_ctc();
		t_block();
		t_force();
		t_ext();
		tally_and_finish();
	end
endmodule : test_timer_counter_two_compare
`default_nettype wire
